/* lcsc_pkg.sv */
package lcsc_pkg;
	// Cycle kinds requested by the host side
	typedef enum logic [2:0] {
		LCSC_CYC_MEM_RD = 3'h0,
		LCSC_CYC_MEM_WR = 3'h1,
		LCSC_CYC_IO_RD = 3'h2,
		LCSC_CYC_IO_WR = 3'h3,
		LCSC_CYC_DMA_RD = 3'h4,
		LCSC_CYC_DMA_WR = 3'h5
	} lcsc_cyc_t;

	typedef enum logic [1:0] {
		LCSC_ST_IDLE = 2'h0,
		LCSC_ST_SETUP = 2'h1,
		LCSC_ST_STROBE = 2'h2,
		LCSC_ST_HOLD = 2'h3
	} lcsc_state_t;

	// Timing in ns and derived cycles at 40 MHz
	localparam int LCSC_CLK_NS = 25;
	localparam int LCSC_SETUP_NS = 30;
	localparam int LCSC_STROBE_NS = 150;
	localparam int LCSC_HOLD_NS = 20;
	localparam int LCSC_SETUP_CYC = (LCSC_SETUP_NS + LCSC_CLK_NS - 1) / LCSC_CLK_NS;
	localparam int LCSC_STROBE_CYC = (LCSC_STROBE_NS + LCSC_CLK_NS - 1) / LCSC_CLK_NS;
	localparam int LCSC_HOLD_CYC = (LCSC_HOLD_NS + LCSC_CLK_NS - 1) / LCSC_CLK_NS;
	localparam int LCSC_CNT_W = 4;
	localparam logic [LCSC_CNT_W-1:0] LCSC_CNT_ZERO = 4'h0;
	localparam logic [LCSC_CNT_W-1:0] LCSC_CNT_ONE = 4'h1;
	localparam logic [1:0] LCSC_SYNC_RST = 2'h3;
endpackage

/* lcsc_slot_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - Assert I/O read strobe during host I/O read cycles.
// - In DMA write (card to memory) assert I/O read strobe per transfer.
// - Drive I/O write strobe low during host I/O write cycles.
// - In DMA read (memory to card) assert I/O write strobe per transfer.
// - Drive output enable low during host memory read cycles.
// - In DMA write assert output enable as terminal count.
// - Keep attribute select high for all common memory accesses.
// - Attribute select plus memory strobes hits attribute memory, plus I/O strobes I/O.
// - Assert attribute select during DMA cycles with the I/O strobes.
// - Provide a card reset output forcing a hard card reset.
// - Two independent identical slot control sets, A and B.
// - Even bytes use the even card enable, odd bytes the odd one.
// - Memory write strobe latches data; as terminal count in DMA read.
module lcsc_slot_ctrl #(
	parameter int ADDR_W = 26
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [1:0] i_req_valid,
	output logic [1:0] o_req_ready,
	input wire logic [2:0] i_req_kind,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic i_req_attr,
	input wire logic [1:0] i_req_bytes,
	input wire logic i_req_last,
	input wire logic [1:0] i_io_mode,
	input wire logic [1:0] i_card_reset_req,
	output logic [1:0] o_done,
	output logic [1:0] o_card_present,
	output logic [1:0] o_card_busy,
	output logic [1:0] o_card_interrupt_request,
	output logic [1:0] o_dma_request,
	output logic [1:0] o_card_input_ack,
	output logic [1:0] o_slot_reset,
	output logic [1:0] o_oe_n,
	output logic [1:0] o_we_n,
	output logic [1:0] o_io_read_strobe_n,
	output logic [1:0] o_io_write_strobe_n,
	output logic [1:0] o_attr_sel_n,
	output logic [1:0] o_card_enable_even_n,
	output logic [1:0] o_card_enable_odd_n,
	output logic [2*ADDR_W-1:0] o_addr,
	input wire logic [1:0] i_card_input_ack_n,
	input wire logic [1:0] i_ready_n_irq,
	input wire logic [1:0] i_wait_n,
	input wire logic [1:0] i_card_detect_first_n,
	input wire logic [1:0] i_card_detect_second_n
);
	// Kind compare used by every strobe decode
	function automatic logic kind_is(input logic [2:0] k, input lcsc_pkg::lcsc_cyc_t c);
		return k == 3'(c);
	endfunction

	// Counter load; counts above fifteen would need a wider counter
	function automatic logic [lcsc_pkg::LCSC_CNT_W-1:0] cnt_load(input int cyc);
		return cyc[lcsc_pkg::LCSC_CNT_W-1:0];
	endfunction

	// Counter step shared by all timed states
	function automatic logic [lcsc_pkg::LCSC_CNT_W-1:0] cnt_dec(input logic [lcsc_pkg::LCSC_CNT_W-1:0] c);
		return c - lcsc_pkg::LCSC_CNT_ONE;
	endfunction

	// One identical engine per slot; no shared state between them
	for (genvar s = 0; s < 2; s++) begin : g_slot
		lcsc_pkg::lcsc_state_t state_ff, nxt_state;
		logic [lcsc_pkg::LCSC_CNT_W-1:0] cnt_ff, nxt_cnt;
		logic [2:0] kind_ff;
		logic last_ff, attr_ff;
		logic [1:0] bytes_ff;
		logic [ADDR_W-1:0] addr_ff;
		logic [1:0] ack_s, rdy_s, wait_s, cd1_s, cd2_s;
		logic strobing, take, is_dma, kind_legal;
		logic active, cnt_last;
		logic present_ff, busy_ff, irq_ff, ack_ff, card_reset_ff;
		logic [3:0] strobes;
		logic st_oe, st_we, st_ior, st_iow;

		// Pins come from the card, two flops first
		always_ff @(posedge i_ref_clk) begin
			if (i_reset) begin
				ack_s <= lcsc_pkg::LCSC_SYNC_RST;
				rdy_s <= lcsc_pkg::LCSC_SYNC_RST;
				wait_s <= lcsc_pkg::LCSC_SYNC_RST;
				cd1_s <= lcsc_pkg::LCSC_SYNC_RST;
				cd2_s <= lcsc_pkg::LCSC_SYNC_RST;
			end else begin
				ack_s <= {ack_s[0], i_card_input_ack_n[s]};
				rdy_s <= {rdy_s[0], i_ready_n_irq[s]};
				wait_s <= {wait_s[0], i_wait_n[s]};
				cd1_s <= {cd1_s[0], i_card_detect_first_n[s]};
				cd2_s <= {cd2_s[0], i_card_detect_second_n[s]};
			end
		end

		// Status leaves on flops; one more cycle of latency buys glitch-free outputs
		always_ff @(posedge i_ref_clk) begin
			present_ff <= ~cd1_s[1] & ~cd2_s[1];
			busy_ff <= ~i_io_mode[s] & ~rdy_s[1];
			irq_ff <= i_io_mode[s] & ~rdy_s[1];
			ack_ff <= ~ack_s[1];
			card_reset_ff <= i_card_reset_req[s];
		end

		assign o_card_present[s] = present_ff;
		assign o_card_busy[s] = busy_ff;
		assign o_card_interrupt_request[s] = irq_ff;
		assign o_card_input_ack[s] = ack_ff;
		assign o_dma_request[s] = ack_ff;
		assign o_slot_reset[s] = card_reset_ff;

		// Kinds six and seven are dropped, never taken
		assign kind_legal = i_req_kind <= 3'h5;
		assign take = (state_ff == lcsc_pkg::LCSC_ST_IDLE) & i_req_valid[s] & kind_legal;
		assign o_req_ready[s] = (state_ff == lcsc_pkg::LCSC_ST_IDLE);
		assign is_dma = kind_ff[2];
		assign strobing = (state_ff == lcsc_pkg::LCSC_ST_STROBE);

		assign active = (state_ff != lcsc_pkg::LCSC_ST_IDLE);
		assign cnt_last = (cnt_ff == lcsc_pkg::LCSC_CNT_ONE);

		// One strobe decoded from the latched kind, plus oe or we on a DMA last transfer
		assign st_oe = strobing & (kind_is(kind_ff, lcsc_pkg::LCSC_CYC_MEM_RD)
			| (kind_is(kind_ff, lcsc_pkg::LCSC_CYC_DMA_WR) & last_ff));
		assign st_we = strobing & (kind_is(kind_ff, lcsc_pkg::LCSC_CYC_MEM_WR)
			| (kind_is(kind_ff, lcsc_pkg::LCSC_CYC_DMA_RD) & last_ff));
		assign st_ior = strobing & (kind_is(kind_ff, lcsc_pkg::LCSC_CYC_IO_RD)
			| kind_is(kind_ff, lcsc_pkg::LCSC_CYC_DMA_WR));
		assign st_iow = strobing & (kind_is(kind_ff, lcsc_pkg::LCSC_CYC_IO_WR)
			| kind_is(kind_ff, lcsc_pkg::LCSC_CYC_DMA_RD));
		// Terminal count on oe or we rides beside the I/O strobe of a DMA cycle
		assign strobes = {st_oe, st_we, st_ior, st_iow};
		assign o_oe_n[s] = ~strobes[3];
		assign o_we_n[s] = ~strobes[2];
		assign o_io_read_strobe_n[s] = ~strobes[1];
		assign o_io_write_strobe_n[s] = ~strobes[0];

		// Latched fields, so nothing moves while a strobe is out
		assign o_attr_sel_n[s] = ~(active & (attr_ff | is_dma));
		assign o_card_enable_even_n[s] = ~(active & bytes_ff[0]);
		assign o_card_enable_odd_n[s] = ~(active & bytes_ff[1]);
		assign o_addr[s*ADDR_W +: ADDR_W] = addr_ff;
		assign o_done[s] = (state_ff == lcsc_pkg::LCSC_ST_HOLD) & cnt_last;

		// Wait is looked at only once the minimum strobe has run
		always_comb begin
			nxt_state = state_ff;
			nxt_cnt = cnt_ff;
			case (state_ff)
				lcsc_pkg::LCSC_ST_IDLE: begin
					if (take) begin
						nxt_state = lcsc_pkg::LCSC_ST_SETUP;
						nxt_cnt = cnt_load(lcsc_pkg::LCSC_SETUP_CYC);
					end
				end
				lcsc_pkg::LCSC_ST_SETUP: begin
					nxt_cnt = cnt_dec(cnt_ff);
					if (cnt_last) begin
						nxt_state = lcsc_pkg::LCSC_ST_STROBE;
						nxt_cnt = cnt_load(lcsc_pkg::LCSC_STROBE_CYC);
					end
				end
				lcsc_pkg::LCSC_ST_STROBE: begin
					if (cnt_ff > lcsc_pkg::LCSC_CNT_ONE) begin
						nxt_cnt = cnt_dec(cnt_ff);
					end else if (wait_s[1]) begin
						nxt_state = lcsc_pkg::LCSC_ST_HOLD;
						nxt_cnt = cnt_load(lcsc_pkg::LCSC_HOLD_CYC);
					end
				end
				lcsc_pkg::LCSC_ST_HOLD: begin
					nxt_cnt = cnt_dec(cnt_ff);
					if (cnt_last) begin
						nxt_state = lcsc_pkg::LCSC_ST_IDLE;
						nxt_cnt = lcsc_pkg::LCSC_CNT_ZERO;
					end
				end
				default: begin
					nxt_state = lcsc_pkg::LCSC_ST_IDLE;
					nxt_cnt = lcsc_pkg::LCSC_CNT_ZERO;
				end
			endcase
		end

		always_ff @(posedge i_ref_clk) begin
			if (i_reset) begin
				state_ff <= lcsc_pkg::LCSC_ST_IDLE;
				cnt_ff <= lcsc_pkg::LCSC_CNT_ZERO;
			end else begin
				state_ff <= nxt_state;
				cnt_ff <= nxt_cnt;
			end
		end

		// Request fields captured only on take
		always_ff @(posedge i_ref_clk) begin
			if (i_reset) begin
				kind_ff <= 3'h0;
				last_ff <= 1'b0;
				attr_ff <= 1'b0;
				bytes_ff <= 2'h0;
				addr_ff <= '0;
			end else if (take) begin
				kind_ff <= i_req_kind;
				last_ff <= i_req_last;
				attr_ff <= i_req_attr;
				bytes_ff <= i_req_bytes;
				addr_ff <= i_req_addr;
			end
		end
	end
endmodule

/* lcsc_slot_ctrl_checker.sv */
`timescale 1ns/1ps
module lcsc_slot_ctrl_checker (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [1:0] i_req_valid,
	input wire logic [1:0] o_req_ready,
	input wire logic [2:0] i_req_kind,
	input wire logic i_req_attr,
	input wire logic [1:0] i_req_bytes,
	input wire logic i_req_last,
	input wire logic [1:0] i_card_reset_req,
	input wire logic [1:0] o_done,
	input wire logic [1:0] o_slot_reset,
	input wire logic [1:0] o_oe_n,
	input wire logic [1:0] o_we_n,
	input wire logic [1:0] o_io_read_strobe_n,
	input wire logic [1:0] o_io_write_strobe_n,
	input wire logic [1:0] o_attr_sel_n,
	input wire logic [1:0] o_card_enable_even_n,
	input wire logic [1:0] o_card_enable_odd_n
);
	// Slot A only, except card reset which checks both slots; slot B shares the same logic
	wire logic tk = i_req_valid[0] & o_req_ready[0] & (i_req_kind < 3'h6);
	wire logic [3:0] stb = {o_oe_n[0], o_we_n[0], o_io_read_strobe_n[0], o_io_write_strobe_n[0]};
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	io_read_a: assert property (tk && i_req_kind == 3'h2 |-> ##3 (!stb[1]) [*6] ##[1:40] o_done[0])
		else $error("io read");
	dma_write_a: assert property (tk && i_req_kind == 3'h5 && i_req_last |-> ##3 stb == 4'h5 && !o_attr_sel_n[0])
		else $error("dma write");
	dma_read_a: assert property (tk && i_req_kind == 3'h4 && i_req_last |-> ##3 stb == 4'hA && !o_attr_sel_n[0])
		else $error("dma read");
	attr_mem_a: assert property (tk && i_req_kind < 3'h2 |-> ##3 o_attr_sel_n[0] == !$past(i_req_attr, 3))
		else $error("attr select");
	one_strobe_a: assert property (o_attr_sel_n[0] |-> $onehot0(~stb))
		else $error("two strobes");
	hold_stable_a: assert property (stb != 4'hF && $past(stb) != 4'hF |-> $stable({o_attr_sel_n[0], o_card_enable_even_n[0], o_card_enable_odd_n[0]}))
		else $error("select moved");
	card_reset_a: assert property (o_slot_reset == $past(i_card_reset_req))
		else $error("card reset");
	byte_lane_a: assert property (tk |-> ##3 {o_card_enable_odd_n[0], o_card_enable_even_n[0]} == ~$past(i_req_bytes, 3))
		else $error("byte lanes");
endmodule
bind lcsc_slot_ctrl lcsc_slot_ctrl_checker chk_u (.*);

/* lcsc_card_model.sv */
`timescale 1ns/1ps
module lcsc_card_model (
	input wire logic i_ref_clk,
	input wire logic [1:0] i_io_read_strobe_n,
	input wire logic [1:0] i_strobe_n,
	input wire logic i_slow,
	input wire logic [1:0] i_busy,
	output logic [1:0] o_input_ack_n,
	output logic [1:0] o_ready_n_irq,
	output logic [1:0] o_wait_n,
	output logic [1:0] o_detect_n
);
	logic [3:0] cnt_ff [2];
	always_ff @(posedge i_ref_clk) begin
		for (int s = 0; s < 2; s++) cnt_ff[s] <= i_strobe_n[s] ? 4'h0 : cnt_ff[s] + 4'h1;
	end
	// Ten cycles outlasts the six-cycle strobe, so the stretch is seen
	always_comb begin
		for (int s = 0; s < 2; s++) o_wait_n[s] = !(i_slow && !i_strobe_n[s] && cnt_ff[s] < 4'hA);
	end
	assign o_input_ack_n = i_io_read_strobe_n;
	assign o_ready_n_irq = ~i_busy;
	assign o_detect_n = 2'h0;
endmodule

/* legacy_card_slot_control_tb.sv */
`timescale 1ns/1ps
module legacy_card_slot_control_tb;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_req_attr = 1'b0;
	logic i_req_last = 1'b0;
	logic slow = 1'b0;
	logic [2:0] i_req_kind = 3'h0;
	logic [25:0] i_req_addr = 26'h0;
	logic [1:0] i_req_valid = 2'h0, i_req_bytes = 2'h3, i_io_mode = 2'h0, i_card_reset_req = 2'h0, busy = 2'h0;
	logic [1:0] o_req_ready, o_done, o_card_present, o_card_busy, o_card_interrupt_request, o_dma_request;
	logic [1:0] o_card_input_ack, o_slot_reset, o_oe_n, o_we_n, o_io_read_strobe_n, o_io_write_strobe_n;
	logic [1:0] o_attr_sel_n, o_card_enable_even_n, o_card_enable_odd_n, i_card_input_ack_n, i_ready_n_irq, i_wait_n;
	logic [1:0] i_card_detect_first_n;
	wire logic [1:0] i_card_detect_second_n = i_card_detect_first_n;
	logic [51:0] o_addr;
	logic [31:0] r = 32'h00017E6E;
	int fail_count = 0;
	int n_compared = 0;
	initial begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	lcsc_slot_ctrl dut_u (.*);
	lcsc_card_model card_u (.i_ref_clk(i_ref_clk), .i_io_read_strobe_n(o_io_read_strobe_n),
		.i_strobe_n(o_oe_n & o_we_n & o_io_read_strobe_n & o_io_write_strobe_n), .i_slow(slow), .i_busy(busy),
		.o_input_ack_n(i_card_input_ack_n), .o_ready_n_irq(i_ready_n_irq), .o_wait_n(i_wait_n),
		.o_detect_n(i_card_detect_first_n));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Strobes as {oe, we, io read, io write}, active low
	function automatic logic [3:0] exp_stb(input logic [2:0] k, input logic l);
		return k < 3'h4 ? ~(4'h8 >> k) : k == 3'h4 ? ~{1'b0, l, 2'h1} : k == 3'h5 ? ~{l, 2'h1, 1'b0} : 4'hF;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic op(input int s, input logic [2:0] k, input logic l);
		int n;
		n = 0;
		r = lfsr(r);
		@(posedge i_ref_clk);
		#1;
		i_req_kind = k;
		i_req_last = l;
		i_req_addr = r[25:0];
		i_req_attr = r[7];
		i_req_bytes = r[9:8] == 2'h0 ? 2'h1 : r[9:8];
		i_req_valid[s] = 1'b1;
		@(posedge i_ref_clk);
		#1;
		i_req_valid[s] = 1'b0;
		repeat (2) @(posedge i_ref_clk);
		#1;
		chk("strobes", exp_stb(k, l), {o_oe_n[s], o_we_n[s], o_io_read_strobe_n[s], o_io_write_strobe_n[s]});
		chk("ready", k > 3'h5, o_req_ready[s]);
		if (k < 3'h6) begin
			chk("addr", i_req_addr, o_addr[s*26 +: 26]);
			chk("attr", {3'h0, k < 3'h4 && !i_req_attr}, {3'h0, o_attr_sel_n[s]});
			chk("lanes", {2'h0, ~i_req_bytes}, {2'h0, o_card_enable_odd_n[s], o_card_enable_even_n[s]});
			while (o_done[s] !== 1'b1 && n < 40) begin
				@(posedge i_ref_clk);
				#1;
				n++;
			end
			chk("done", 4'h1, {3'h0, o_done[s]});
			// Card stretch is ten cycles, then two sync flops before the hold
			chk("span", slow ? 10 + 2 + lcsc_pkg::LCSC_HOLD_CYC : lcsc_pkg::LCSC_STROBE_CYC + lcsc_pkg::LCSC_HOLD_CYC - 1, n);
			chk("ack", {2{k == 3'h2 || k == 3'h5}}, {o_card_input_ack[s], o_dma_request[s]});
		end
	endtask
	initial begin
		repeat (16) @(posedge i_ref_clk);
		#1;
		i_reset = 1'b0;
		repeat (3) @(posedge i_ref_clk);
		#1;
		chk("present", 4'h3, {2'h0, o_card_present});
		for (int k = 0; k < 14; k++) op(0, k[3:1], k[0]);
		op(1, 3'h2, 1'b0);
		slow = 1'b1;
		op(0, 3'h3, 1'b0);
		slow = 1'b0;
		for (int i = 0; i < 16; i++) begin
			r = lfsr(r);
			i_card_reset_req = r[1:0];
			i_io_mode = r[11:10];
			busy = r[13:12];
			repeat (3) @(posedge i_ref_clk);
			#1;
			chk("reset", {2'h0, r[1:0]}, {2'h0, o_slot_reset});
			chk("busy", {2'h0, ~i_io_mode & busy}, {2'h0, o_card_busy});
			chk("irq", {2'h0, i_io_mode & busy}, {2'h0, o_card_interrupt_request});
			op(r[2], r[5:3] % 3'h6, r[6]);
		end
		conclude();
	end
	// Thirty-two ops of a dozen cycles; this allows many times that
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule
